// ---- design/sld_pkg.sv ----
package sld_pkg;

    // =================================================================
    // serial path geometry
    localparam int DOT_BITS = 160;
    localparam int CTL_BITS = 8;
    localparam int WORD_BITS = 7;
    localparam int CTL_SELECT_BIT = 7;

    // =================================================================
    // control word fields
    localparam int CW0_AWAKE_BIT = 6;
    localparam int CW1_SIMUL_BIT = 0;
    localparam int CW1_PRESCALE_BIT = 1;
    localparam logic [WORD_BITS-1:0] WORD_RST = 7'h00;

    // =================================================================
    // display clock
    localparam int PRESCALE_DIV = 8;
    localparam int PRESCALE_W = $clog2(PRESCALE_DIV);
    localparam int REFRESH_CYCLES = 512;
    localparam int REFRESH_W = $clog2(REFRESH_CYCLES);
    localparam int OSC_HALF_W = 16;
    localparam logic [OSC_HALF_W-1:0] OSC_HALF_RST = 16'h0064;

    // =================================================================
    // register map
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_WORD0 = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_WORD1 = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_OSC_HALF = 8'h0c;
    localparam logic [3:0] HIT_NONE = 4'h0;
    localparam logic [3:0] HIT_WORD0 = 4'h1;
    localparam logic [3:0] HIT_WORD1 = 4'h2;
    localparam logic [3:0] HIT_STATUS = 4'h4;
    localparam logic [3:0] HIT_OSC_HALF = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // =================================================================
    // pin synchroniser lanes
    localparam int PIN_N = 7;
    localparam int PIN_SDI = 0;
    localparam int PIN_WCLK = 1;
    localparam int PIN_CE_N = 2;
    localparam int PIN_TSEL = 3;
    localparam int PIN_OSC_SEL = 4;
    localparam int PIN_OSC_IN = 5;
    localparam int PIN_BLANK = 6;
    localparam logic [PIN_N-1:0] PIN_RST = 7'h04;

endpackage

// ---- design/sld_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module sld_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // meta_r feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ---- design/sld_loader.sv ----
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module sld_loader #(
    parameter int DOT_BITS = sld_pkg::DOT_BITS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [sld_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sld_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_din,
    input wire logic write_clk,
    input wire logic chip_enable_n,
    input wire logic target_select,
    input wire logic osc_select,
    input wire logic refresh_osc_pin_in,
    output logic refresh_osc_pin_out,
    output logic refresh_osc_pin_oe_n,
    input wire logic blank_input,
    output logic serial_dout,
    output logic [DOT_BITS-1:0] led_dots,
    output logic display_awake,
    output logic [sld_pkg::REFRESH_W-1:0] refresh_phase
);

    // =================================================================
    // pin synchronisers
    logic [sld_pkg::PIN_N-1:0] pins_raw;
    logic [sld_pkg::PIN_N-1:0] pins_q;
    logic sdi_q, wclk_q, ce_q, tsel_q, osc_sel_q, osc_in_q, blank_q;

    // plain level pins, so a chained pair can share every line except serial_din
    assign pins_raw = {blank_input, refresh_osc_pin_in, osc_select,
                       target_select, chip_enable_n, write_clk, serial_din};

    sld_sync #(
        .WIDTH(sld_pkg::PIN_N),
        .RST_VAL(sld_pkg::PIN_RST)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(pins_raw),
        .sync_out(pins_q)
    );

    assign sdi_q = pins_q[sld_pkg::PIN_SDI];
    assign wclk_q = pins_q[sld_pkg::PIN_WCLK];
    assign ce_q = pins_q[sld_pkg::PIN_CE_N];
    assign tsel_q = pins_q[sld_pkg::PIN_TSEL];
    assign osc_sel_q = pins_q[sld_pkg::PIN_OSC_SEL];
    assign osc_in_q = pins_q[sld_pkg::PIN_OSC_IN];
    assign blank_q = pins_q[sld_pkg::PIN_BLANK];

    // =================================================================
    // edge detection and transfer control
    logic wclk_d_r, ce_d_r, osc_in_d_r;
    logic wclk_rise, ce_fall, shift_en, sel_now, xfer;
    logic sel_ctl_r, pending_r;

    assign wclk_rise = wclk_q & ~wclk_d_r;
    assign ce_fall = ~ce_q & ce_d_r;
    // selection may fall in the same cycle as a clock edge
    assign sel_now = ce_fall ? tsel_q : sel_ctl_r;
    assign shift_en = wclk_rise & ~ce_q;
    assign xfer = pending_r & ce_q & ~wclk_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wclk_d_r <= 1'b0;
            ce_d_r <= 1'b1;
            osc_in_d_r <= 1'b0;
        end else begin
            wclk_d_r <= wclk_q;
            ce_d_r <= ce_q;
            osc_in_d_r <= osc_in_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_ctl_r <= 1'b0;
        end else if (ce_fall) begin
            sel_ctl_r <= tsel_q;
        end
    end

    // any enable-low period arms exactly one transfer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pending_r <= 1'b0;
        end else if (ce_fall) begin
            pending_r <= 1'b1;
        end else if (xfer) begin
            pending_r <= 1'b0;
        end
    end

    // =================================================================
    // dot path: no reset, contents survive it
    logic [DOT_BITS-1:0] dot_shift_r;
    logic [DOT_BITS-1:0] dot_latch_r;

    always_ff @(posedge aclk) begin
        if (shift_en && !sel_now) begin
            dot_shift_r <= {dot_shift_r[DOT_BITS-2:0], sdi_q};
        end
    end

    always_ff @(posedge aclk) begin
        if (xfer && !sel_ctl_r) begin
            dot_latch_r <= dot_shift_r;
        end
    end

    // =================================================================
    // control path
    logic [sld_pkg::CTL_BITS-1:0] ctl_shift_r;
    logic [sld_pkg::WORD_BITS-1:0] word0_r, word1_r;
    logic awake, simul_mode, prescale_on;

    assign awake = word0_r[sld_pkg::CW0_AWAKE_BIT];
    assign simul_mode = word1_r[sld_pkg::CW1_SIMUL_BIT];
    assign prescale_on = word1_r[sld_pkg::CW1_PRESCALE_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_shift_r <= '0;
        end else if (shift_en && sel_now) begin
            // first bit in ends up at the top: msb first
            ctl_shift_r <= {ctl_shift_r[sld_pkg::CTL_BITS-2:0], sdi_q};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word0_r <= sld_pkg::WORD_RST;
            word1_r <= sld_pkg::WORD_RST;
        end else if (xfer && sel_ctl_r) begin
            if (ctl_shift_r[sld_pkg::CTL_SELECT_BIT]) begin
                word1_r <= ctl_shift_r[sld_pkg::WORD_BITS-1:0];
            end else begin
                word0_r <= ctl_shift_r[sld_pkg::WORD_BITS-1:0];
            end
        end
    end

    // =================================================================
    // serial output and led drive
    logic sdo_r;
    logic [DOT_BITS-1:0] led_dots_r;
    logic awake_r;

    // end of the selected chain feeds the next driver's input; control in simul_mode passes serial_din
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sdo_r <= 1'b0;
        end else if (sel_ctl_r) begin
            sdo_r <= simul_mode ? sdi_q :
                     ctl_shift_r[sld_pkg::CTL_SELECT_BIT];
        end else begin
            sdo_r <= dot_shift_r[DOT_BITS-1];
        end
    end

    // dark while asleep, so random dot contents do not show until the display is woken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_dots_r <= '0;
            awake_r <= 1'b0;
        end else begin
            led_dots_r <= (awake && !blank_q) ? dot_latch_r : '0;
            awake_r <= awake;
        end
    end

    // =================================================================
    // refresh oscillator
    logic [sld_pkg::OSC_HALF_W-1:0] osc_half_r, osc_cnt_r;
    logic int_osc_r, osc_out_r, osc_oe_n_r;
    logic [sld_pkg::PRESCALE_W-1:0] pre_cnt_r;
    logic [sld_pkg::REFRESH_W-1:0] phase_r;
    logic int_wrap, ext_rise, disp_tick;

    assign int_wrap = (osc_cnt_r + 16'h0001) >= osc_half_r;
    assign ext_rise = osc_in_q & ~osc_in_d_r;
    assign disp_tick = osc_sel_q ? (int_wrap & ~int_osc_r)
        : (ext_rise & (~prescale_on | (&pre_cnt_r)));

    // internal source stops in sleep, as does its pin
    always_ff @(posedge aclk) begin
        if (!aresetn || !awake || !osc_sel_q) begin
            osc_cnt_r <= '0;
            int_osc_r <= 1'b0;
        end else if (int_wrap) begin
            osc_cnt_r <= '0;
            int_osc_r <= ~int_osc_r;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_out_r <= 1'b0;
            osc_oe_n_r <= 1'b1;
        end else begin
            osc_out_r <= int_osc_r;
            osc_oe_n_r <= ~osc_sel_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || osc_sel_q) begin
            pre_cnt_r <= '0;
        end else if (ext_rise) begin
            pre_cnt_r <= pre_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_r <= '0;
        end else if (awake && disp_tick) begin
            phase_r <= phase_r + 9'h001;
        end
    end

    // =================================================================
    // register bus
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_full_r, w_full_r;
    logic [sld_pkg::ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r, wr_hit;
    logic [1:0] bresp_r, rresp_r;
    logic do_write;

    function automatic logic [3:0] addr_hit(
        input logic [sld_pkg::ADDR_W-1:0] addr
    );
        if (addr == sld_pkg::ADDR_WORD0) begin
            return sld_pkg::HIT_WORD0;
        end else if (addr == sld_pkg::ADDR_WORD1) begin
            return sld_pkg::HIT_WORD1;
        end else if (addr == sld_pkg::ADDR_STATUS) begin
            return sld_pkg::HIT_STATUS;
        end else if (addr == sld_pkg::ADDR_OSC_HALF) begin
            return sld_pkg::HIT_OSC_HALF;
        end else begin
            return sld_pkg::HIT_NONE;
        end
    endfunction

    assign do_write = aw_full_r & w_full_r & ~bvalid_r;
    assign wr_hit = addr_hit(awaddr_r);

    // one write at a time: readies come back after the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= sld_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                awaddr_r <= s_axi_awaddr;
                aw_full_r <= 1'b1;
                awready_r <= 1'b0;
            end
            if (s_axi_wvalid && wready_r) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                w_full_r <= 1'b1;
                wready_r <= 1'b0;
            end
            if (do_write) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_hit == sld_pkg::HIT_NONE) ?
                    sld_pkg::RESP_SLVERR : sld_pkg::RESP_OKAY;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_half_r <= sld_pkg::OSC_HALF_RST;
        end else if (do_write && wr_hit == sld_pkg::HIT_OSC_HALF) begin
            if (wstrb_r[0]) osc_half_r[7:0] <= wdata_r[7:0];
            if (wstrb_r[1]) osc_half_r[15:8] <= wdata_r[15:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= sld_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_r) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= sld_pkg::RESP_OKAY;
            case (addr_hit(s_axi_araddr))
                sld_pkg::HIT_WORD0: rdata_r <= {25'h0, word0_r};
                sld_pkg::HIT_WORD1: rdata_r <= {25'h0, word1_r};
                sld_pkg::HIT_STATUS: rdata_r <= {26'h0, pending_r,
                    sel_ctl_r, blank_q, osc_sel_q, ce_q, awake};
                sld_pkg::HIT_OSC_HALF: rdata_r <= {16'h0, osc_half_r};
                default: begin
                    rdata_r <= '0;
                    rresp_r <= sld_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign serial_dout = sdo_r;
    assign led_dots = led_dots_r;
    assign display_awake = awake_r;
    assign refresh_osc_pin_out = osc_out_r;
    assign refresh_osc_pin_oe_n = osc_oe_n_r;
    assign refresh_phase = phase_r;

    // =================================================================
    // checks
    chk_reset_clears_ctl: assert property (@(posedge aclk)
        $fell(aresetn) ##1 !aresetn |-> word0_r == '0 && word1_r == '0)
        else $error("control words not cleared by reset");
    chk_dots_survive_reset: assert property (@(posedge aclk)
        !aresetn |=> dot_latch_r === $past(dot_latch_r))
        else $error("dot latch changed during reset");
    chk_dot_shift_in: assert property (@(posedge aclk)
        disable iff (!aresetn) shift_en && !sel_now
        |=> dot_shift_r
            === {$past(dot_shift_r[DOT_BITS-2:0]), $past(sdi_q)})
        else $error("dot bit not shifted in");
    chk_ctl_route: assert property (@(posedge aclk)
        disable iff (!aresetn) shift_en && sel_now |=> ctl_shift_r
            == {$past(ctl_shift_r[6:0]), $past(sdi_q)}
            && dot_shift_r === $past(dot_shift_r))
        else $error("control bit misrouted");
    chk_sel_capture: assert property (@(posedge aclk)
        disable iff (!aresetn) ce_fall ##1 !ce_q [*3]
        |-> sel_ctl_r == $past(tsel_q, 3))
        else $error("select not held from enable fall");
    chk_dot_transfer: assert property (@(posedge aclk)
        disable iff (!aresetn) xfer && !sel_ctl_r
        |=> dot_latch_r === $past(dot_shift_r) && !pending_r)
        else $error("dot transfer missed");
    chk_idle_no_shift: assert property (@(posedge aclk)
        disable iff (!aresetn) ce_q && ce_d_r && wclk_rise
        |=> $stable(ctl_shift_r) && dot_shift_r === $past(dot_shift_r))
        else $error("shift while enable high");
    chk_word_select: assert property (@(posedge aclk)
        disable iff (!aresetn) xfer && sel_ctl_r && ctl_shift_r[7]
        |=> word1_r == $past(ctl_shift_r[6:0]) && $stable(word0_r))
        else $error("wrong control word loaded");
    chk_simul_follow: assert property (@(posedge aclk)
        disable iff (!aresetn) sel_ctl_r && simul_mode
        |=> serial_dout == $past(sdi_q))
        else $error("output not following input");
    chk_blank_dark: assert property (@(posedge aclk)
        disable iff (!aresetn) blank_q || !awake |=> led_dots == '0)
        else $error("leds lit while blanked or asleep");
    chk_osc_drive: assert property (@(posedge aclk)
        disable iff (!aresetn) osc_sel_q ##1 osc_sel_q
        |-> !refresh_osc_pin_oe_n)
        else $error("oscillator pin not driven");

endmodule

`default_nettype wire

// ---- tb/sld_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module sld_host (
    output logic write_clk,
    output logic chip_enable_n,
    output logic target_select,
    output logic serial_din
);
    initial begin
        write_clk = 1'b0;
        chip_enable_n = 1'b1;
        target_select = 1'b0;
        serial_din = 1'b0;
    end

    // ==========
    // frames, msb first; write clock rests low outside frames
    task automatic send(input logic s, input int n,
        input logic [159:0] b);
        // offsets keep every pin change off the sampling edge
        #10 target_select = s;
        #20 chip_enable_n = 1'b0;
        #150 target_select = ~s; // device must hold its captured copy
        for (int i = n - 1; i >= 0; i--) begin
            serial_din = b[i];
            #160 write_clk = 1'b1;
            #160 write_clk = 1'b0;
        end
        #160 chip_enable_n = 1'b1;
        serial_din = ~serial_din; // released line does not keep its bit
        #380;
    endtask

    task automatic stray;
        #20 write_clk = 1'b1;
        #160 write_clk = 1'b0;
        #140;
    endtask
endmodule

`default_nettype wire

// ---- tb/tb_serial_led_matrix_loader.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_serial_led_matrix_loader;
    logic aclk = 1'b0, aresetn = 1'b0, ext_osc = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, osc_select = 1'b1;
    logic blank_input = 1'b0, lvl;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic serial_din, write_clk, chip_enable_n, target_select;
    logic refresh_osc_pin_in, refresh_osc_pin_out;
    logic refresh_osc_pin_oe_n, serial_dout, display_awake;
    logic [159:0] led_dots, vec;
    logic [sld_pkg::REFRESH_W-1:0] refresh_phase, ph;
    int err_total = 0, cmp_count = 0;

    // pin level: external source unless the device drives it
    assign refresh_osc_pin_in = refresh_osc_pin_oe_n ? ext_osc
                                                     : refresh_osc_pin_out;

    always #20 aclk = ~aclk;
    always #1000 ext_osc = ~ext_osc;

    sld_loader u_dut (.*);
    sld_host u_host (.*);

    // ==========
    // checking and closing
    task automatic chk(input logic [159:0] got, input logic [159:0] e);
        cmp_count++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask

    task automatic complete_run;
        $display("errors %0d, compares %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic tmo;
        err_total++;
        complete_run();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wait_dots(input logic [159:0] e);
        int n;
        n = 0;
        while (led_dots !== e && n < 40) begin
            @(posedge aclk);
            n++;
        end
        if (led_dots !== e) tmo();
        chk(led_dots, e);
    endtask

    // ==========
    // register bus
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        rsp = s_axi_bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
            if (n > 50) tmo();
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
    endtask

    // ==========
    // scenarios
    task automatic t_reset;
        chk(led_dots, '0);
        chk(display_awake, 1'b0);
        axi_rd(8'h00);
        chk(rd, 32'h0);
        axi_rd(8'h04);
        chk(rd, 32'h0);
        axi_rd(8'h0c);
        chk(rd, 32'h64);
    endtask

    task automatic t_wake;
        u_host.send(1'b1, 8, 160'h40);
        axi_rd(8'h00);
        chk(rd, 32'h40);
        chk(display_awake, 1'b1);
        chk(refresh_osc_pin_oe_n, 1'b0);
    endtask

    task automatic t_dots;
        vec = {32{5'b10110}};
        u_host.send(1'b0, 160, vec);
        wait_dots(vec);
        chk(serial_dout, vec[159]);
        u_host.stray();
        u_host.send(1'b0, 0, '0);
        wait_dots(vec);
        axi_rd(8'h00);
        chk(rd, 32'h40);
    endtask

    task automatic t_blank;
        blank_input <= 1'b1;
        wait_dots('0);
        blank_input <= 1'b0;
        wait_dots(vec);
    endtask

    task automatic t_word1;
        u_host.send(1'b1, 8, 160'h81);
        axi_rd(8'h04);
        chk(rd, 32'h01);
        axi_rd(8'h00);
        chk(rd, 32'h40);
        chk(serial_dout, serial_din);
    endtask

    task automatic t_osc;
        // internal source: half period 0x64 cycles, one tick per period
        ph = refresh_phase;
        lvl = refresh_osc_pin_out;
        cyc(100);
        chk(refresh_osc_pin_out, !lvl);
        cyc(100);
        chk(refresh_phase != ph, 1'b1);
        osc_select <= 1'b0;
        cyc(8);
        chk(refresh_osc_pin_oe_n, 1'b1);
        ph = refresh_phase;
        cyc(200);
        chk(refresh_phase != ph, 1'b1);
        // prescaler on: 18 external rises give two or three ticks
        u_host.send(1'b1, 8, 160'h83);
        ph = refresh_phase;
        cyc(900);
        chk((refresh_phase - ph) inside {9'h002, 9'h003}, 1'b1);
    endtask

    task automatic t_regs;
        axi_wr(8'h0c, 32'h123);
        chk(rsp, 2'h0);
        axi_rd(8'h0c);
        chk(rd, 32'h123);
        axi_rd(8'h10);
        chk(rsp, 2'h2);
        axi_wr(8'h00, 32'h7f);
        chk(rsp, 2'h0);
        axi_wr(8'h10, 32'h1);
        chk(rsp, 2'h2);
        axi_rd(8'h08);
        chk(rd, 32'h13);
        axi_rd(8'h00);
        chk(rd, 32'h40);
    endtask

    task automatic t_rst;
        @(posedge aclk);
        aresetn <= 1'b0;
        cyc(6);
        aresetn <= 1'b1;
        cyc(3);
        chk(display_awake, 1'b0);
        chk(led_dots, '0);
        axi_rd(8'h04);
        chk(rd, 32'h0);
        u_host.send(1'b1, 8, 160'h40);
        wait_dots(vec);
    endtask

    initial begin
        cyc(6);
        aresetn <= 1'b1;
        cyc(3);
        t_reset();
        t_wake();
        t_dots();
        t_blank();
        t_word1();
        t_osc();
        t_regs();
        t_rst();
        complete_run();
    end
endmodule

`default_nettype wire
